// file: protocol_timer_control.sv
// protocol timer: mode control, prescaler, reload, gating and avalon registers
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/100ps
// Function
// - auto-start at transmission end, except in a cycle that also has a stop event
// - single receive: stop after fifth bit
// - multi receive: only stop-now command or expiry stops
// - auto-start off ignores protocol events
// - gate select: none, card pin, aux pin
// - active flag ignores momentary gate level
// - auto-reload restarts from reload value
// - no reload: stop at zero, flag expired
// - twelve-bit prescaler split over two registers
// - even select 0: divide by 2p+1
// - even select 1: divide by 2p+2
// - load counter at start events and on auto-reload at zero
module protocol_timer_control
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // protocol events from the transceiver
  input  wire logic              txDone,
  input  wire logic              rxBitStrobe,
  input  wire logic              rxFrameStart,
  // reference 13.56 mhz clock and gate pins, asynchronous
  input  wire logic              refClock,
  input  wire logic              card_signal_input,
  input  wire logic              auxiliary_pin_one,
  // interrupt and status
  output logic                   irq,
  output logic                   timer_active_flag
);

  // registers
  logic [7:0]        tmode_q;
  logic [7:0]        presc_q;
  logic [15:0]       reload_value_q;
  logic              multi_receive_enable_q;
  logic              even_divide_select_q;
  logic [IRQ_W-1:0]  irqStat_q;
  logic [IRQ_W-1:0]  irqMask_q;
  logic [15:0]       count_q;
  logic [15:0]       count_d;
  logic              running_q;
  logic              running_d;
  logic [2:0]        rxBits_q;
  logic              refLast_q;
  bus_state_t        bus_q;

  // synchronised pins
  wire  [2:0]        syncPins;
  wire               refSync  = syncPins[0];
  wire               cardSync = syncPins[1];
  wire               auxSync  = syncPins[2];

  pin_sync #(.W(3)) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pinIn   ({auxiliary_pin_one, card_signal_input, refClock}),
    .pinOut  (syncPins)
  );

  // mode fields
  wire               auto_start_enable  = tmode_q[TM_AUTO_BIT];
  wire [1:0]         gate_select        = tmode_q[TM_GATE_HI:TM_GATE_LO];
  wire               auto_reload_enable = tmode_q[TM_RELOAD_BIT];
  wire [3:0]         prescaler_high_bits = tmode_q[TM_PRESC_HI:0];
  wire [PRESC_W-1:0] prescaler = {prescaler_high_bits, presc_q};

  // bus decode
  wire [7:0]  regIdx   = avs_address[ADDR_W-1:2];
  wire        accept   = (bus_q == BUS_IDLE) && (avs_read || avs_write);
  wire        wrLane0  = accept && avs_write && avs_byteenable[0];
  wire [7:0]  wrByte   = avs_writedata[7:0];

  // register hits, used by the read mux and, except count and status, by the write strobes
  wire        hitTmode  = (regIdx == IDX_TMODE);
  wire        hitPresc  = (regIdx == IDX_TPRESC);
  wire        hitRelHi  = (regIdx == IDX_RELOAD_HI);
  wire        hitRelLo  = (regIdx == IDX_RELOAD_LO);
  wire        hitCntHi  = (regIdx == IDX_COUNT_HI);
  wire        hitCntLo  = (regIdx == IDX_COUNT_LO);
  wire        hitCtrl   = (regIdx == IDX_CONTROL);
  wire        hitStatus = (regIdx == IDX_STATUS);
  wire        hitIStat  = (regIdx == IDX_IRQ_STAT);
  wire        hitIMask  = (regIdx == IDX_IRQ_MASK);

  wire        wrTmode  = wrLane0 && hitTmode;
  wire        wrPresc  = wrLane0 && hitPresc;
  wire        wrRelHi  = wrLane0 && hitRelHi;
  wire        wrRelLo  = wrLane0 && hitRelLo;
  wire        wrCtrl   = wrLane0 && hitCtrl;
  wire        wrIStat  = wrLane0 && hitIStat;
  wire        wrIMask  = wrLane0 && hitIMask;
  wire        stopCmd  = wrCtrl && wrByte[CT_STOP_BIT];
  wire        startCmd = wrCtrl && wrByte[CT_START_BIT];

  // protocol events only act with auto-start set
  wire        autoStart = auto_start_enable && txDone;
  wire        fifthBit  = rxBitStrobe && (rxBits_q == STOP_BIT_COUNT - 3'h1);
  // multi receive never stops on reception
  wire        autoStop  = auto_start_enable && !multi_receive_enable_q && fifthBit;
  wire        startEv   = autoStart || startCmd;
  wire        stopEv    = autoStop || stopCmd;

  // gating; code 11 treated as never gated open
  wire        gateOpen = (gate_select == GATE_NONE) ? 1'b1 :
                         (gate_select == GATE_CARD) ? cardSync :
                         (gate_select == GATE_AUXILIARY_PIN_ONE) ? auxSync : 1'b0;

  wire        refEdge = refSync && !refLast_q;
  wire        tick;

  tick_divider #(.W(PRESC_W)) u_div (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .refEdge    (refEdge),
    .run        (running_q && gateOpen),
    .prescaler  (prescaler),
    .evenDivide (even_divide_select_q),
    .tick       (tick)
  );

  wire        countTick = running_q && gateOpen && tick;
  wire        atZero    = (count_q == 16'h0000);
  wire        expire    = countTick && atZero && !auto_reload_enable;

  // counter next value; start loads the reload value, stop wins over start
  always_comb begin
    count_d   = count_q;
    running_d = running_q;
    if (stopEv) begin
      running_d = 1'b0;
    end else if (startEv) begin
      count_d   = reload_value_q;
      running_d = 1'b1;
    end else if (countTick) begin
      if (!atZero) begin
        count_d = count_q - 16'h0001;
      end else if (auto_reload_enable) begin
        count_d = reload_value_q;
      end else begin
        running_d = 1'b0;
      end
    end
  end

  // interrupt status: set wins over write-one-to-clear
  wire [IRQ_W-1:0] irqSet   = {expire};
  wire [IRQ_W-1:0] irqClear = wrIStat ? wrByte[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] irqStat_d = irqSet | (irqStat_q & ~irqClear);

  // read views of the packed registers; strobe bits always read zero
  wire [7:0]  ctrlView   = {4'h0, even_divide_select_q, multi_receive_enable_q, 2'b00};
  wire [7:0]  statusView = {7'h00, running_q};
  wire [7:0]  iStatView  = {{(8-IRQ_W){1'b0}}, irqStat_q};
  wire [7:0]  iMaskView  = {{(8-IRQ_W){1'b0}}, irqMask_q};

  // read mux
  wire [7:0]  rdByte =
    hitTmode  ? tmode_q :
    hitPresc  ? presc_q :
    hitRelHi  ? reload_value_q[15:8] :
    hitRelLo  ? reload_value_q[7:0] :
    hitCntHi  ? count_q[15:8] :
    hitCntLo  ? count_q[7:0] :
    hitCtrl   ? ctrlView :
    hitStatus ? statusView :
    hitIStat  ? iStatView :
    hitIMask  ? iMaskView : 8'h00;

  // timer mode: auto start, gate select, auto reload, prescaler high bits
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tmode_q <= RST_TMODE;
    end else if (wrTmode) begin
      tmode_q <= wrByte;
    end
  end

  // prescaler low byte
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      presc_q <= RST_TPRESC;
    end else if (wrPresc) begin
      presc_q <= wrByte;
    end
  end

  // reload halves are independent; a running count keeps its old start value
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reload_value_q <= {RST_RELOAD, RST_RELOAD};
    end else begin
      if (wrRelHi) reload_value_q[15:8] <= wrByte;
      if (wrRelLo) reload_value_q[7:0] <= wrByte;
    end
  end

  // control: start and stop are strobes, only the mode bits are kept
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      multi_receive_enable_q <= 1'b0;
      even_divide_select_q   <= 1'b0;
    end else if (wrCtrl) begin
      multi_receive_enable_q <= wrByte[CT_MULTI_BIT];
      even_divide_select_q   <= wrByte[CT_EVEN_BIT];
    end
  end

  // interrupt mask
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irqMask_q <= '0;
    end else if (wrIMask) begin
      irqMask_q <= wrByte[IRQ_W-1:0];
    end
  end

  // count and run state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count_q   <= 16'h0000;
      running_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      running_q <= running_d;
    end
  end

  // last reference level, for the rising edge detect
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      refLast_q <= 1'b0;
    end else begin
      refLast_q <= refSync;
    end
  end

  // sticky interrupt status
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irqStat_q <= '0;
    end else begin
      irqStat_q <= irqStat_d;
    end
  end

  // received-bit counter, restarted on each frame
  always_ff @(posedge mclk) begin
    if (sys_rst || rxFrameStart || startEv) begin
      rxBits_q <= 3'h0;
    end else if (rxBitStrobe && rxBits_q != STOP_BIT_COUNT) begin
      rxBits_q <= rxBits_q + 3'h1;
    end
  end

  // bus answer: one wait cycle, answer on the second edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_q           <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      case (bus_q)
        BUS_IDLE: begin
          if (accept) begin
            bus_q           <= BUS_ANSWER;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= {24'h000000, rdByte};
          end
        end
        BUS_ANSWER: begin
          bus_q           <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_q           <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // interrupt level from the next status, so it rises with the status bit
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_d & irqMask_q);
    end
  end

  // active flag shows enable, not the gate level
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timer_active_flag <= 1'b0;
    end else begin
      timer_active_flag <= running_d;
    end
  end

endmodule

// file: timer_pkg.sv
// constants, offsets and field layout for the protocol timer block
package timer_pkg;

  // register offsets; printed offsets are not all multiples of four, so they are indices
  localparam logic [7:0] IDX_TMODE     = 8'h2a;
  localparam logic [7:0] IDX_TPRESC    = 8'h2b;
  localparam logic [7:0] IDX_RELOAD_HI = 8'h2c;
  localparam logic [7:0] IDX_RELOAD_LO = 8'h2d;
  localparam logic [7:0] IDX_COUNT_HI  = 8'h2e;
  localparam logic [7:0] IDX_COUNT_LO  = 8'h2f;
  localparam logic [7:0] IDX_CONTROL   = 8'h30;
  localparam logic [7:0] IDX_STATUS    = 8'h31;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'h32;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h33;
  localparam int         ADDR_W        = 10;

  // timer mode field positions
  localparam int TM_AUTO_BIT    = 7;
  localparam int TM_GATE_HI     = 6;
  localparam int TM_GATE_LO     = 5;
  localparam int TM_RELOAD_BIT  = 4;
  localparam int TM_PRESC_HI    = 3;
  // control register bits
  localparam int CT_STOP_BIT    = 0;
  localparam int CT_START_BIT   = 1;
  localparam int CT_MULTI_BIT   = 2;
  localparam int CT_EVEN_BIT    = 3;
  // status bits
  localparam int ST_ACTIVE_BIT  = 0;
  // interrupt bits
  localparam int IRQ_EXPIRED    = 0;
  localparam int IRQ_W          = 1;

  localparam logic [7:0] RST_TMODE  = 8'h00;
  localparam logic [7:0] RST_TPRESC = 8'h00;
  localparam logic [7:0] RST_RELOAD = 8'h00;

  localparam logic [1:0] GATE_NONE = 2'b00;
  localparam logic [1:0] GATE_CARD = 2'b01;
  localparam logic [1:0] GATE_AUXILIARY_PIN_ONE = 2'b10;

  // bits received before the timer stops in single-receive mode
  localparam logic [2:0] STOP_BIT_COUNT = 3'h5;
  localparam int         PRESC_W        = 12;

  typedef enum logic [1:0] {BUS_IDLE, BUS_ANSWER} bus_state_t;

endpackage

// file: tick_divider.sv
// prescaler dividing the 13.56 MHz reference into timer ticks
`timescale 1ns/100ps
module tick_divider
  import timer_pkg::*;
#(
  parameter int W = PRESC_W
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // control
  input  wire logic         refEdge,
  input  wire logic         run,
  input  wire logic [W-1:0] prescaler,
  input  wire logic         evenDivide,
  // tick out
  output logic              tick
);

  logic [W:0] divCount_q;
  logic [W:0] divCount_d;
  wire  [W:0] divLimit;
  wire        atLimit;

  // period is 2p+1 or 2p+2 reference cycles, so limit is 2p or 2p+1
  assign divLimit   = {prescaler, evenDivide};
  assign atLimit    = (divCount_q == divLimit);
  assign divCount_d = !run ? '0 : !refEdge ? divCount_q : atLimit ? '0 : divCount_q + 1'b1;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      divCount_q <= '0;
      tick       <= 1'b0;
    end else begin
      divCount_q <= divCount_d;
      tick       <= run && refEdge && atLimit;
    end
  end

endmodule

// file: pin_sync.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // pins
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);

  logic [W-1:0] meta_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= '0;
      pinOut <= '0;
    end else begin
      meta_q <= pinIn;
      pinOut <= meta_q;
    end
  end

endmodule

// file: protocol_timer_chk.sv
// assertion checker watching the protocol timer control ports
`timescale 1ns/100ps
module protocol_timer_chk
  import timer_pkg::*;
(
  // clock, reset and bus
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  // events and outputs
  input wire logic              txDone,
  input wire logic              rxBitStrobe,
  input wire logic              rxFrameStart,
  input wire logic              irq,
  input wire logic              timer_active_flag
);
  logic [7:0] idx;
  logic       acc;
  logic       auto_q;
  logic       multi_q;
  logic       mask_q;
  logic [2:0] rxCnt_q;
  assign idx = avs_address[9:2];
  assign acc = avs_write && !avs_waitrequest && avs_byteenable[0];
  // shadows lag the design by one edge, so they only guard quiet stretches
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      auto_q  <= 1'b0;
      multi_q <= 1'b0;
      mask_q  <= 1'b0;
      rxCnt_q <= 3'h0;
    end else begin
      if (acc && idx == IDX_TMODE) auto_q <= avs_writedata[TM_AUTO_BIT];
      if (acc && idx == IDX_CONTROL) multi_q <= avs_writedata[CT_MULTI_BIT];
      if (acc && idx == IDX_IRQ_MASK) mask_q <= avs_writedata[IRQ_EXPIRED];
      if (rxFrameStart || txDone) rxCnt_q <= 3'h0;
      else if (rxBitStrobe && rxCnt_q != 3'h7) rxCnt_q <= rxCnt_q + 3'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait state");
  a_answer_short: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0 ##1 avs_waitrequest)
    else $error("answer longer than one cycle or upper read bits set");
  a_auto_start: assert property (auto_q && txDone && !rxBitStrobe |-> ##[1:3] timer_active_flag)
    else $error("transmission end did not start timer");
  a_rx_stop: assert property (auto_q && !multi_q && rxBitStrobe && rxCnt_q == 3'h4 && !txDone
    |-> ##[1:3] !timer_active_flag)
    else $error("timer kept running after fifth received bit");
  a_multi_hold: assert property (auto_q && multi_q && timer_active_flag && rxBitStrobe && !avs_write
    |=> timer_active_flag)
    else $error("reception stopped timer in multi receive");
  a_no_auto: assert property (!auto_q && txDone && !timer_active_flag && !avs_write && !$past(avs_write)
    |=> !timer_active_flag [*3])
    else $error("transmission end started timer with auto start off");
  a_stop_now: assert property (acc && idx == IDX_CONTROL && avs_writedata[CT_STOP_BIT] && !txDone
    |-> ##[1:2] !timer_active_flag)
    else $error("stop command did not stop timer");
  a_irq_masked: assert property (!mask_q && !$past(mask_q) |-> !irq)
    else $error("interrupt raised while masked");
  a_irq_clear: assert property (acc && idx == IDX_IRQ_STAT && avs_writedata[IRQ_EXPIRED] && !timer_active_flag
    |=> !irq)
    else $error("interrupt stayed after clear");
  c_expiry: cover property ($fell(timer_active_flag));
  c_irq: cover property ($rose(irq));
  c_auto: cover property (auto_q && txDone);
endmodule
bind protocol_timer_control protocol_timer_chk u_protocol_timer_chk (.mclk, .sys_rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .txDone, .rxBitStrobe,
  .rxFrameStart, .irq, .timer_active_flag);

// file: tb_protocol_timer_control.sv
// self-checking bench for the protocol timer control block
`timescale 1ns/100ps
module tb_protocol_timer_control;
  import timer_pkg::*;
  logic              mclk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = '0;
  logic [3:0]        avs_byteenable = 4'hf;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              txDone = 1'b0;
  logic              rxBitStrobe = 1'b0;
  logic              rxFrameStart = 1'b0;
  logic              refClock = 1'b0;
  logic              card_signal_input = 1'b0;
  logic              auxiliary_pin_one = 1'b0;
  logic              irq;
  logic              timer_active_flag;
  logic [2:0]        refDiv = 3'h0;
  logic [7:0]        rdat;
  int                mismatches = 0;
  int                compares = 0;
  int                n;
  always #10 mclk = ~mclk;
  // reference at one eighth of mclk, well below the synchroniser limit
  always @(posedge mclk) refDiv <= refDiv + 3'h1;
  always @(posedge mclk) refClock <= refDiv[2];
  protocol_timer_control u_protocol_timer_control (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .txDone, .rxBitStrobe, .rxFrameStart,
    .refClock, .card_signal_input, .auxiliary_pin_one, .irq, .timer_active_flag);
  task wrap_up;
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [7:0] i, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    rdat = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task rd(input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk(rdat, e);
  endtask
  task flag(input int w, input logic e);
    repeat (w) @(posedge mclk);
    chk({7'h0, timer_active_flag}, {7'h0, e});
  endtask
  task pulse(input logic [2:0] m);
    @(posedge mclk);
    {rxFrameStart, rxBitStrobe, txDone} <= m;
    @(posedge mclk);
    {rxFrameStart, rxBitStrobe, txDone} <= 3'h0;
  endtask
  // start, then time the run; reference phase and sync add a few cycles of slack
  task tm(input logic [7:0] c, input int e);
    bus(1'b1, IDX_CONTROL, c);
    repeat (2) @(posedge mclk);
    n = 0;
    while (timer_active_flag === 1'b1 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    compares++;
    if (n < e - 24 || n > e + 24) begin
      mismatches++;
      $display("MISMATCH t=%0t run took %0d cycles", $time, n);
    end
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(IDX_TMODE, RST_TMODE);
    rd(IDX_TPRESC, RST_TPRESC);
    rd(8'hff, 8'h00);
    bus(1'b1, IDX_TMODE, 8'h0a);
    rd(IDX_TMODE, 8'h0a);
    avs_byteenable <= 4'he;
    bus(1'b1, IDX_TMODE, 8'hff);
    avs_byteenable <= 4'hf;
    rd(IDX_TMODE, 8'h0a);
    bus(1'b1, IDX_TMODE, 8'h00);
    bus(1'b1, IDX_TPRESC, 8'h01);
    bus(1'b1, IDX_RELOAD_LO, 8'h07);
    bus(1'b1, IDX_IRQ_MASK, 8'h01);
    tm(8'h02, 192);
    rd(IDX_IRQ_STAT, 8'h01);
    chk({7'h0, irq}, 8'h01);
    bus(1'b1, IDX_IRQ_STAT, 8'h01);
    rd(IDX_IRQ_STAT, 8'h00);
    tm(8'h0a, 256);
    bus(1'b1, IDX_TMODE, 8'h01);
    bus(1'b1, IDX_RELOAD_LO, 8'h00);
    tm(8'h02, 4120);
    bus(1'b1, IDX_RELOAD_LO, 8'h07);
    bus(1'b1, IDX_IRQ_MASK, 8'h00);
    repeat (3) @(posedge mclk);
    chk({7'h0, irq}, 8'h00);
    bus(1'b1, IDX_IRQ_STAT, 8'h01);
    bus(1'b1, IDX_TMODE, 8'h10);
    bus(1'b1, IDX_CONTROL, 8'h02);
    flag(600, 1'b1);
    rd(IDX_IRQ_STAT, 8'h00);
    bus(1'b1, IDX_CONTROL, 8'h01);
    bus(1'b1, IDX_TMODE, 8'h20);
    bus(1'b1, IDX_CONTROL, 8'h02);
    flag(300, 1'b1);
    rd(IDX_COUNT_LO, 8'h07);
    card_signal_input <= 1'b1;
    flag(300, 1'b0);
    bus(1'b1, IDX_TMODE, 8'h40);
    bus(1'b1, IDX_CONTROL, 8'h02);
    flag(300, 1'b1);
    rd(IDX_COUNT_LO, 8'h07);
    auxiliary_pin_one <= 1'b1;
    card_signal_input <= 1'b0;
    flag(300, 1'b0);
    card_signal_input <= 1'b1;
    bus(1'b1, IDX_TMODE, 8'h60);
    bus(1'b1, IDX_CONTROL, 8'h02);
    bus(1'b1, IDX_RELOAD_LO, 8'h30);
    flag(300, 1'b1);
    rd(IDX_COUNT_LO, 8'h07);
    rd(IDX_STATUS, 8'h01);
    bus(1'b1, IDX_CONTROL, 8'h01);
    bus(1'b1, IDX_IRQ_STAT, 8'h01);
    bus(1'b1, IDX_RELOAD_HI, 8'h10);
    bus(1'b1, IDX_TMODE, 8'h80);
    pulse(3'b001);
    flag(2, 1'b1);
    rd(IDX_COUNT_HI, 8'h10);
    pulse(3'b100);
    repeat (4) pulse(3'b010);
    flag(2, 1'b1);
    pulse(3'b010);
    flag(3, 1'b0);
    bus(1'b1, IDX_CONTROL, 8'h04);
    pulse(3'b001);
    pulse(3'b100);
    repeat (6) pulse(3'b010);
    flag(2, 1'b1);
    bus(1'b1, IDX_CONTROL, 8'h05);
    flag(2, 1'b0);
    rd(IDX_CONTROL, 8'h04);
    bus(1'b1, IDX_CONTROL, 8'h00);
    bus(1'b1, IDX_TMODE, 8'h00);
    repeat (2) @(posedge mclk);
    pulse(3'b001);
    flag(3, 1'b0);
    bus(1'b1, IDX_CONTROL, 8'h02);
    pulse(3'b100);
    repeat (5) pulse(3'b010);
    flag(2, 1'b1);
    bus(1'b1, IDX_CONTROL, 8'h01);
    wrap_up();
  end
endmodule
